// ===== pkg/hcc_pkg.sv
// constants and types shared by the host cpu, coprocessor and cache interface
package hcc_pkg;

    localparam int ADDR_W = 24;
    localparam int MID_LSB = 8;
    localparam int MID_W = 9;
    localparam int TAG_W = 7;
    localparam int TAG_LSB_DEF = 16;
    localparam int SYNC_W = 53;

    // status decode {mem_or_io_n, data_or_ctrl_n, write_or_read_n}
    localparam logic [2:0] CYC_INTA = 3'h0;
    localparam logic [2:0] CYC_IO_RD = 3'h2;
    localparam logic [2:0] CYC_IO_WR = 3'h3;
    localparam logic [2:0] CYC_CODE_RD = 3'h4;
    localparam logic [2:0] CYC_HALT = 3'h5;
    localparam logic [2:0] CYC_MEM_RD = 3'h6;
    localparam logic [2:0] CYC_MEM_WR = 3'h7;

    // coprocessor i/o ports: top address bit set and low byte in f8..ff; the error clear port f0 needs no top bit
    localparam int FPU_SEL_BIT = 23;
    localparam logic [7:0] FPU_PORT_BASE = 8'hf8;
    localparam logic [7:0] FPU_PORT_MASK = 8'hf8;
    localparam logic [7:0] FPU_CLR_PORT = 8'hf0;

    // one t-state is two periods of the 2x master clock
    localparam int T_STATE_CLKS = 2;
    localparam int FILL_WORDS = 4;

    // dma byte placement inside the a[16:8] field
    localparam int DMA16_POS = 1;
    localparam int DMA8_POS = 0;

    localparam logic RST_HIGH = 1'b1;
    localparam logic [1:0] RST_WE_N = 2'h3;
    localparam logic [MID_W-1:0] RST_MID_OE_N = 9'h1ff;

    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_T2 = 7'h02,
        ST_LOCAL = 7'h04,
        ST_RDHIT = 7'h08,
        ST_FILL = 7'h10,
        ST_WRITE = 7'h20,
        ST_DONE = 7'h40
    } hcc_state_t;

endpackage : hcc_pkg

// ===== logic/hcc_sync2.sv
// two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/100ps
`default_nettype none
module hcc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync;

    always_comb begin
        next_meta = i_clk_en ? i_async : meta;
        next_sync = i_clk_en ? meta : o_sync;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta <= RST_VAL;
            o_sync <= RST_VAL;
        end else begin
            meta <= next_meta;
            o_sync <= next_sync;
        end
    end
endmodule : hcc_sync2
`default_nettype wire

// ===== logic/hcc_host_if.sv
// host cpu cycle decode, dma address turnaround, coprocessor status and cache control
`timescale 1ns/100ps
`default_nettype none
module hcc_host_if #(
    parameter int TAG_LSB = hcc_pkg::TAG_LSB_DEF,
    parameter int FILL_WORDS = hcc_pkg::FILL_WORDS
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic i_addr_status_n,
    input wire logic i_mem_or_io_n,
    input wire logic i_data_or_ctrl_n,
    input wire logic i_write_or_read_n,
    input wire logic i_high_byte_enable_n,
    input wire logic [6:0] i_cpu_addr_hi,
    input wire logic [7:0] i_cpu_addr_lo,
    input wire logic [8:0] i_cpu_addr_mid,
    output logic [8:0] o_cpu_addr_mid,
    output logic [8:0] o_cpu_addr_mid_oe_n,
    output logic o_ready_n,
    input wire logic i_dma8_addr_strobe,
    input wire logic i_dma16_addr_strobe,
    input wire logic i_dma8_enable_n,
    input wire logic i_dma16_enable_n,
    input wire logic [7:0] i_periph_data_low,
    input wire logic i_fpu_error_n,
    input wire logic i_fpu_busy_in_n,
    output logic o_busy_n,
    output logic o_fpu_irq_n,
    input wire logic i_local_ready_in_n,
    input wire logic i_local_claim_n,
    output logic o_cache_oe_n,
    output logic [1:0] o_cache_byte_we_n,
    output logic o_tagram_we_n,
    input wire logic [6:0] i_tag,
    output logic [6:0] o_tag,
    output logic o_tag_oe_n,
    input wire logic i_dirty_bit,
    output logic o_dirty_bit,
    output logic o_dirty_bit_oe_n,
    output logic o_cache_a1_toggle,
    output logic o_cache_a2_toggle
);
    localparam int FILL_CLKS = FILL_WORDS * hcc_pkg::T_STATE_CLKS;
    localparam int CNT_W = $clog2(FILL_CLKS);

    ////////////////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers: every input here comes from off-chip
    logic [hcc_pkg::SYNC_W-1:0] raw_in;
    logic [hcc_pkg::SYNC_W-1:0] sync_in;
    logic ads_s, mio_s, dc_s, wr_s, bhe_s;
    logic [hcc_pkg::ADDR_W-1:0] addr_s;
    logic s8_s, s16_s, aen8_s, aen16_s;
    logic [7:0] xd_s;
    logic err_s, busy_s, rdy_s, claim_s, dirty_s;
    logic [6:0] tag_s;

    assign raw_in = {i_addr_status_n, i_mem_or_io_n, i_data_or_ctrl_n, i_write_or_read_n,
                     i_high_byte_enable_n, i_cpu_addr_hi, i_cpu_addr_mid, i_cpu_addr_lo,
                     i_dma8_addr_strobe, i_dma16_addr_strobe, i_dma8_enable_n, i_dma16_enable_n,
                     i_periph_data_low, i_fpu_error_n, i_fpu_busy_in_n, i_local_ready_in_n,
                     i_local_claim_n, i_tag, i_dirty_bit};

    // local ready crosses here: the two stages are the one t-state it costs
    hcc_sync2 #(.W(hcc_pkg::SYNC_W), .RST_VAL('1)) u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_clk_en(i_clk_en),
        .i_async(raw_in),
        .o_sync(sync_in)
    );

    assign {ads_s, mio_s, dc_s, wr_s, bhe_s, addr_s, s8_s, s16_s, aen8_s, aen16_s,
            xd_s, err_s, busy_s, rdy_s, claim_s, tag_s, dirty_s} = sync_in;

    ////////////////////////////////////////////////////////////////////////////////////////////
    // dma address turnaround onto a[16:8]
    logic [7:0] dma_byte, next_dma_byte;
    logic [8:0] next_mid, next_mid_oe_n;

    always_comb begin
        next_dma_byte = dma_byte;
        if (s16_s || s8_s) begin
            next_dma_byte = xd_s;
        end
        next_mid = o_cpu_addr_mid;
        next_mid_oe_n = hcc_pkg::RST_MID_OE_N;
        if (!aen16_s) begin
            next_mid[hcc_pkg::DMA16_POS +: 8] = dma_byte;
            next_mid_oe_n[hcc_pkg::DMA16_POS +: 8] = 8'h00;
        end else if (!aen8_s) begin
            next_mid[hcc_pkg::DMA8_POS +: 8] = dma_byte;
            next_mid_oe_n[hcc_pkg::DMA8_POS +: 8] = 8'h00;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dma_byte <= 8'h00;
            o_cpu_addr_mid <= 9'h000;
            o_cpu_addr_mid_oe_n <= hcc_pkg::RST_MID_OE_N;
        end else if (i_clk_en) begin
            dma_byte <= next_dma_byte;
            o_cpu_addr_mid <= next_mid;
            o_cpu_addr_mid_oe_n <= next_mid_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // cpu cycle state machine and cache strobes
    hcc_pkg::hcc_state_t state, next_state;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic [2:0] cyc, next_cyc;
    logic [hcc_pkg::ADDR_W-1:0] addr, next_addr;
    logic [1:0] lanes, next_lanes;
    logic next_ready_n, next_oe_n, next_tag_we_n, next_dirty_out, next_a1, next_a2;
    logic [1:0] next_we_n;
    logic [6:0] next_tag_out;
    logic [CNT_W-1:0] fill_word;
    logic is_read, tag_hit, cyc_start, word_last;

    assign cyc_start = (state == hcc_pkg::ST_IDLE) && !ads_s;
    assign is_read = (cyc == hcc_pkg::CYC_MEM_RD) || (cyc == hcc_pkg::CYC_CODE_RD);
    assign tag_hit = (tag_s == addr[TAG_LSB +: hcc_pkg::TAG_W]);
    assign fill_word = cnt / CNT_W'(hcc_pkg::T_STATE_CLKS);
    assign word_last = (cnt % CNT_W'(hcc_pkg::T_STATE_CLKS)) == CNT_W'(hcc_pkg::T_STATE_CLKS - 1);

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_cyc = cyc;
        next_addr = addr;
        next_lanes = lanes;
        next_ready_n = 1'b1;
        next_oe_n = 1'b1;
        next_we_n = hcc_pkg::RST_WE_N;
        next_tag_we_n = 1'b1;
        next_tag_out = o_tag;
        next_dirty_out = o_dirty_bit;
        next_a1 = o_cache_a1_toggle;
        next_a2 = o_cache_a2_toggle;
        unique case (state)
            hcc_pkg::ST_IDLE: begin
                if (cyc_start) begin
                    next_state = hcc_pkg::ST_T2;
                    next_cyc = {mio_s, dc_s, wr_s};
                    next_addr = addr_s;
                    next_lanes = {!bhe_s, !addr_s[0]};
                end
            end
            hcc_pkg::ST_T2: begin
                next_cnt = '0;
                if (!claim_s) begin
                    next_state = hcc_pkg::ST_LOCAL;
                end else if (is_read) begin
                    next_state = tag_hit ? hcc_pkg::ST_RDHIT : hcc_pkg::ST_FILL;
                end else if (cyc == hcc_pkg::CYC_MEM_WR) begin
                    next_state = tag_hit ? hcc_pkg::ST_WRITE : hcc_pkg::ST_DONE;
                end else begin
                    next_state = hcc_pkg::ST_DONE;
                end
            end
            hcc_pkg::ST_LOCAL: begin
                if (!rdy_s) begin
                    next_state = hcc_pkg::ST_DONE;
                end
            end
            hcc_pkg::ST_RDHIT: begin
                next_oe_n = 1'b0;
                next_cnt = cnt + 1'b1;
                if (word_last) begin
                    next_state = hcc_pkg::ST_DONE;
                end
            end
            hcc_pkg::ST_FILL: begin
                next_a1 = fill_word[0];
                next_a2 = fill_word[1];
                next_cnt = cnt + 1'b1;
                if (cnt == '0) begin
                    next_tag_we_n = 1'b0;
                    next_tag_out = addr[TAG_LSB +: hcc_pkg::TAG_W];
                    next_dirty_out = 1'b0;
                end
                if (word_last) begin
                    next_we_n = 2'b00;
                end
                if (cnt == CNT_W'(FILL_CLKS - 1)) begin
                    next_state = hcc_pkg::ST_DONE;
                end
            end
            hcc_pkg::ST_WRITE: begin
                next_cnt = cnt + 1'b1;
                if (word_last) begin
                    // write hit marks the line dirty for the later write-back
                    next_we_n = ~lanes;
                    next_tag_we_n = 1'b0;
                    next_tag_out = addr[TAG_LSB +: hcc_pkg::TAG_W];
                    next_dirty_out = 1'b1;
                    next_state = hcc_pkg::ST_DONE;
                end
            end
            hcc_pkg::ST_DONE: begin
                next_ready_n = 1'b0;
                next_a1 = 1'b0;
                next_a2 = 1'b0;
                next_state = hcc_pkg::ST_IDLE;
            end
            default: begin
                next_state = hcc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= hcc_pkg::ST_IDLE;
            cnt <= '0;
            cyc <= 3'h0;
            addr <= '0;
            lanes <= 2'h0;
            o_ready_n <= hcc_pkg::RST_HIGH;
            o_cache_oe_n <= hcc_pkg::RST_HIGH;
            o_cache_byte_we_n <= hcc_pkg::RST_WE_N;
            o_tagram_we_n <= hcc_pkg::RST_HIGH;
            o_tag_oe_n <= hcc_pkg::RST_HIGH;
            o_dirty_bit_oe_n <= hcc_pkg::RST_HIGH;
            o_tag <= 7'h00;
            o_dirty_bit <= 1'b0;
            o_cache_a1_toggle <= 1'b0;
            o_cache_a2_toggle <= 1'b0;
        end else if (i_clk_en) begin
            state <= next_state;
            cnt <= next_cnt;
            cyc <= next_cyc;
            addr <= next_addr;
            lanes <= next_lanes;
            o_ready_n <= next_ready_n;
            o_cache_oe_n <= next_oe_n;
            o_cache_byte_we_n <= next_we_n;
            o_tagram_we_n <= next_tag_we_n;
            o_tag_oe_n <= next_tag_we_n;
            o_dirty_bit_oe_n <= next_tag_we_n;
            o_tag <= next_tag_out;
            o_dirty_bit <= next_dirty_out;
            o_cache_a1_toggle <= next_a1;
            o_cache_a2_toggle <= next_a2;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // coprocessor presence, error latch and busy
    logic present, err_latch, busy_tog;
    logic [1:0] settle, next_settle;
    logic next_present, next_err_latch, next_busy_tog, next_busy_n, next_irq_n;
    logic cyc_is_io, fpu_instr, err_clear;

    assign cyc_is_io = ({mio_s, dc_s} == 2'b01);
    assign fpu_instr = cyc_start && cyc_is_io && addr_s[hcc_pkg::FPU_SEL_BIT]
                       && ((addr_s[7:0] & hcc_pkg::FPU_PORT_MASK) == hcc_pkg::FPU_PORT_BASE);
    assign err_clear = cyc_start && ({mio_s, dc_s, wr_s} == hcc_pkg::CYC_IO_WR)
                       && (addr_s[7:0] == hcc_pkg::FPU_CLR_PORT);

    always_comb begin
        // waits out both synchroniser stages, so their reset value is never taken for the pin
        next_settle = (settle == 2'h3) ? settle : settle + 2'h1;
        next_present = (settle == 2'h2) ? !err_s : present;
        // a new error in the same clock as the clearing write is kept
        next_err_latch = (present && !err_s) || (err_latch && !err_clear);
        next_busy_tog = busy_tog ^ (fpu_instr && !present);
        next_busy_n = !(!busy_s || err_latch || busy_tog);
        next_irq_n = !err_latch;
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            present <= 1'b0;
            settle <= 2'h0;
            err_latch <= 1'b0;
            busy_tog <= 1'b0;
            o_busy_n <= hcc_pkg::RST_HIGH;
            o_fpu_irq_n <= hcc_pkg::RST_HIGH;
        end else if (i_clk_en) begin
            present <= next_present;
            settle <= next_settle;
            err_latch <= next_err_latch;
            busy_tog <= next_busy_tog;
            o_busy_n <= next_busy_n;
            o_fpu_irq_n <= next_irq_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_mid_inputs;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && aen16_s && aen8_s |=> (o_cpu_addr_mid_oe_n == 9'h1ff);
    endproperty
    a_mid_inputs: assert property (p_mid_inputs) else $error("a[16:8] driven outside dma");

    property p_dma16;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && !aen16_s |=> (o_cpu_addr_mid_oe_n == 9'h001) && (o_cpu_addr_mid[8:1] == $past(dma_byte));
    endproperty
    a_dma16: assert property (p_dma16) else $error("16-bit dma address wrong");

    property p_dma8;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && aen16_s && !aen8_s |=> (o_cpu_addr_mid_oe_n == 9'h100)
            && (o_cpu_addr_mid[7:0] == $past(dma_byte));
    endproperty
    a_dma8: assert property (p_dma8) else $error("8-bit dma address wrong");

    property p_dma_latch;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && (s8_s || s16_s) |=> (dma_byte == $past(xd_s));
    endproperty
    a_dma_latch: assert property (p_dma_latch) else $error("dma byte not latched");

    property p_ready;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && (state == hcc_pkg::ST_DONE) |=> !o_ready_n && (state == hcc_pkg::ST_IDLE);
    endproperty
    a_ready: assert property (p_ready) else $error("ready not given after cycle end");

    property p_local;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && (state == hcc_pkg::ST_LOCAL) && !rdy_s |=> (state == hcc_pkg::ST_DONE);
    endproperty
    a_local: assert property (p_local) else $error("local ready not passed on");

    property p_no_contention;
        @(posedge i_clock) disable iff (!i_rst_n)
        !(!o_cache_oe_n && (o_cache_byte_we_n != 2'b11));
    endproperty
    a_no_contention: assert property (p_no_contention) else $error("cache oe and we overlap");

    property p_tag_drive;
        @(posedge i_clock) disable iff (!i_rst_n)
        (o_tag_oe_n == o_tagram_we_n) && (o_dirty_bit_oe_n == o_tagram_we_n)
            && (o_tagram_we_n || (o_tag == addr[TAG_LSB +: hcc_pkg::TAG_W]));
    endproperty
    a_tag_drive: assert property (p_tag_drive) else $error("tag or dirty driven without strobe");

    property p_miss;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && (state == hcc_pkg::ST_FILL) && (cnt == '0) |=> !o_tagram_we_n && !o_dirty_bit;
    endproperty
    a_miss: assert property (p_miss) else $error("read miss missed tag write");

    property p_err;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && err_latch |=> !o_fpu_irq_n && !o_busy_n;
    endproperty
    a_err: assert property (p_err) else $error("error not reported");

    property p_busy;
        @(posedge i_clock) disable iff (!i_rst_n)
        i_clk_en && !busy_s |=> !o_busy_n;
    endproperty
    a_busy: assert property (p_busy) else $error("busy not passed on");

endmodule : hcc_host_if
`default_nettype wire

// ===== test/hcc_far_model.sv
// far-side model: tag and dirty ram plus one local bus device
`timescale 1ns/100ps
`default_nettype none
module hcc_far_model #(
    parameter int READY_DELAY = 8
) (
    input wire logic i_clock,
    input wire logic [6:0] i_tag,
    input wire logic i_tag_oe_n,
    input wire logic i_dirty,
    input wire logic i_dirty_oe_n,
    input wire logic i_tagram_we_n,
    input wire logic i_claim_n,
    output logic [6:0] o_tag,
    output logic o_dirty,
    output logic o_ready_n
);
    // one entry only: index lines are not modelled, every access lands on one line
    logic [6:0] mem_tag = 7'h7f;
    logic mem_dirty = 1'b1;
    int wait_cnt = 0;
    ////////////////////////////////////////////////////////////////////////////
    assign o_tag = i_tag_oe_n ? mem_tag : i_tag;
    assign o_dirty = i_dirty_oe_n ? mem_dirty : i_dirty;
    always @(posedge i_clock) begin
        if (!i_tagram_we_n) begin
            mem_tag <= o_tag;
            mem_dirty <= o_dirty;
        end
        wait_cnt <= i_claim_n ? 0 : wait_cnt + 1;
    end
    // slow on purpose, so a cpu ready that ignores it shows up early
    assign o_ready_n = !(wait_cnt >= READY_DELAY);
endmodule : hcc_far_model
`default_nettype wire

// ===== test/tb_hcc_host_if.sv
// self-checking bench for the host cpu, coprocessor and cache interface
`timescale 1ns/100ps
`default_nettype none
module tb_hcc_host_if;
    logic clk = 0, rst_n = 0, ads_n = 1, mio_n = 1, dc_n = 1, wr_n = 1, hbe_n = 1;
    logic [6:0] a_hi = 0, tag_o, tag_w;
    logic [7:0] a_lo = 0, pd = 0;
    logic [8:0] cpu_mid = 0, mid_o, mid_oe_n, mid_w;
    logic s8 = 0, s16 = 0, en8_n = 1, en16_n = 1, err_n = 0, bsy_in_n = 1, claim_n = 1;
    logic rdy_n, busy_n, irq_n, lrdy_n, oe_n, twe_n, tag_oe_n, drt_w, drt_o, drt_oe_n, t1, t2;
    logic [1:0] we_n, we_and;
    logic saw_oe, saw_twe, twe_drt;
    logic [6:0] twe_tag;
    logic [3:0] seen;
    int cyc, mismatches = 0, n_checks = 0, tick = 0;
    ////////////////////////////////////////////////////////////////////////////
    assign mid_w = (mid_o & ~mid_oe_n) | (cpu_mid & mid_oe_n);
    hcc_host_if u_dut (.i_clock(clk), .i_rst_n(rst_n), .i_clk_en(1'b1), .i_addr_status_n(ads_n),
        .i_mem_or_io_n(mio_n), .i_data_or_ctrl_n(dc_n), .i_write_or_read_n(wr_n),
        .i_high_byte_enable_n(hbe_n), .i_cpu_addr_hi(a_hi), .i_cpu_addr_lo(a_lo),
        .i_cpu_addr_mid(mid_w), .o_cpu_addr_mid(mid_o), .o_cpu_addr_mid_oe_n(mid_oe_n),
        .o_ready_n(rdy_n), .i_dma8_addr_strobe(s8), .i_dma16_addr_strobe(s16),
        .i_dma8_enable_n(en8_n), .i_dma16_enable_n(en16_n), .i_periph_data_low(pd),
        .i_fpu_error_n(err_n), .i_fpu_busy_in_n(bsy_in_n), .o_busy_n(busy_n), .o_fpu_irq_n(irq_n),
        .i_local_ready_in_n(lrdy_n), .i_local_claim_n(claim_n), .o_cache_oe_n(oe_n),
        .o_cache_byte_we_n(we_n), .o_tagram_we_n(twe_n), .i_tag(tag_w), .o_tag(tag_o),
        .o_tag_oe_n(tag_oe_n), .i_dirty_bit(drt_w), .o_dirty_bit(drt_o),
        .o_dirty_bit_oe_n(drt_oe_n), .o_cache_a1_toggle(t1), .o_cache_a2_toggle(t2));
    hcc_far_model #(.READY_DELAY(20)) u_far (.i_clock(clk), .i_tag(tag_o), .i_tag_oe_n(tag_oe_n),
        .i_dirty(drt_o), .i_dirty_oe_n(drt_oe_n), .i_tagram_we_n(twe_n), .i_claim_n(claim_n),
        .o_tag(tag_w), .o_dirty(drt_w), .o_ready_n(lrdy_n));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        tick++;
        if (tick == 5000) begin
            mismatches++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    task automatic check_flag(input string nm, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
        end
    endtask : check_flag
    task automatic check_val(input string nm, input logic [8:0] exp, input logic [8:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : check_val
    task automatic do_reset(input logic e);
        @(negedge clk);
        rst_n = 0;
        err_n = e;
        repeat (12) @(negedge clk);
        rst_n = 1;
        repeat (4) @(negedge clk);
    endtask : do_reset
    // one cpu cycle; ads is held a single clock, then outputs are watched until ready
    task automatic cpu_cycle(input logic [2:0] st, input logic [6:0] hi, input logic [8:0] mid,
        input logic [7:0] lo, input logic hb_n);
        cyc = 0;
        saw_oe = 0;
        saw_twe = 0;
        we_and = 2'h3;
        seen = 4'h0;
        @(negedge clk);
        {mio_n, dc_n, wr_n} = st;
        a_hi = hi;
        cpu_mid = mid;
        a_lo = lo;
        hbe_n = hb_n;
        ads_n = 0;
        @(negedge clk);
        ads_n = 1;
        while (rdy_n !== 1'b0 && cyc < 60) begin
            @(negedge clk);
            cyc++;
            saw_oe |= (oe_n === 1'b0);
            if (twe_n === 1'b0) begin
                saw_twe = 1;
                twe_tag = tag_o;
                twe_drt = drt_o;
            end
            we_and &= we_n;
            if (we_n === 2'h0) begin
                seen[{t2, t1}] = 1'b1;
            end
            check_flag("oe with we", 1'b0, oe_n === 1'b0 && we_n !== 2'h3);
            check_val("tag dirty drive", {7'h0, twe_n, twe_n}, {7'h0, tag_oe_n, drt_oe_n});
        end
        check_flag("ready", 1'b0, rdy_n);
        repeat (2) @(negedge clk);
    endtask : cpu_cycle
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_fpu_present();
        repeat (6) @(negedge clk);
        check_flag("busy on error", 1'b0, busy_n);
        check_flag("irq on error", 1'b0, irq_n);
        err_n = 1;
        cpu_cycle(hcc_pkg::CYC_IO_WR, 7'h00, 9'h000, hcc_pkg::FPU_CLR_PORT, 1'b1);
        repeat (4) @(negedge clk);
        check_flag("busy cleared", 1'b1, busy_n);
        check_flag("irq cleared", 1'b1, irq_n);
        bsy_in_n = 0;
        repeat (5) @(negedge clk);
        check_flag("busy follows", 1'b0, busy_n);
        bsy_in_n = 1;
        repeat (5) @(negedge clk);
        check_flag("busy released", 1'b1, busy_n);
    endtask : t_fpu_present
    task automatic t_plain_cycles();
        logic [2:0] codes [4] = '{hcc_pkg::CYC_INTA, hcc_pkg::CYC_IO_RD, hcc_pkg::CYC_IO_WR,
            hcc_pkg::CYC_HALT};
        foreach (codes[i]) begin
            cpu_cycle(codes[i], 7'h35, 9'h1aa, 8'h00, 1'b0);
            check_val("no cache action", 9'h003, {5'h0, saw_oe, saw_twe, we_and});
        end
    endtask : t_plain_cycles
    task automatic t_read_miss();
        cpu_cycle(hcc_pkg::CYC_MEM_RD, 7'h35, 9'h1aa, 8'h00, 1'b0);
        check_flag("tag write", 1'b1, saw_twe);
        check_val("new tag", 9'h06b, {2'h0, twe_tag});
        check_flag("dirty on fill", 1'b0, twe_drt);
        check_val("fill words", 9'h00f, {5'h0, seen});
        check_val("toggles idle", 9'h000, {7'h0, t2, t1});
    endtask : t_read_miss
    task automatic t_read_hit();
        cpu_cycle(hcc_pkg::CYC_MEM_RD, 7'h35, 9'h1aa, 8'h00, 1'b0);
        check_val("hit oe only", 9'h00b, {5'h0, saw_oe, saw_twe, we_and});
    endtask : t_read_hit
    // one lane at a time, so a swapped lane or a dropped byte enable shows
    task automatic t_write_hit();
        cpu_cycle(hcc_pkg::CYC_MEM_WR, 7'h35, 9'h1aa, 8'h01, 1'b0);
        check_val("high lane we", 9'h001, {7'h0, we_and});
        check_flag("dirty on write", 1'b1, twe_drt);
        cpu_cycle(hcc_pkg::CYC_MEM_WR, 7'h35, 9'h1aa, 8'h00, 1'b1);
        check_val("low lane we", 9'h002, {7'h0, we_and});
    endtask : t_write_hit
    task automatic t_local();
        claim_n = 0;
        cpu_cycle(hcc_pkg::CYC_MEM_RD, 7'h35, 9'h1aa, 8'h00, 1'b0);
        claim_n = 1;
        check_flag("waits local ready", 1'b1, cyc >= 20);
        check_flag("cache idle", 1'b0, saw_oe);
    endtask : t_local
    task automatic t_dma();
        cpu_cycle(hcc_pkg::CYC_IO_RD, 7'h00, 9'h000, 8'h00, 1'b1);
        en16_n = 0;
        pd = 8'ha5;
        s16 = 1;
        repeat (6) @(negedge clk);
        check_val("dma16 addr", 9'h0a5, {1'h0, mid_w[8:1]});
        check_val("dma16 oe", 9'h001, mid_oe_n);
        s16 = 0;
        en16_n = 1;
        en8_n = 0;
        pd = 8'h3c;
        s8 = 1;
        repeat (6) @(negedge clk);
        check_val("dma8 addr", 9'h03c, {1'h0, mid_w[7:0]});
        check_val("dma8 oe", 9'h100, mid_oe_n);
        s8 = 0;
        en8_n = 1;
        repeat (6) @(negedge clk);
        check_val("mid released", 9'h1ff, mid_oe_n);
    endtask : t_dma
    task automatic t_no_fpu();
        do_reset(1'b1);
        err_n = 0;
        repeat (6) @(negedge clk);
        check_flag("absent no irq", 1'b1, irq_n);
        err_n = 1;
        cpu_cycle(hcc_pkg::CYC_IO_WR, 7'h40, 9'h000, 8'hf8, 1'b1);
        check_flag("busy toggled", 1'b0, busy_n);
        cpu_cycle(hcc_pkg::CYC_IO_WR, 7'h40, 9'h000, 8'hff, 1'b1);
        check_flag("busy toggled back", 1'b1, busy_n);
    endtask : t_no_fpu
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(1'b0);
        t_fpu_present();
        t_plain_cycles();
        t_read_miss();
        t_read_hit();
        t_write_hit();
        t_local();
        t_dma();
        t_no_fpu();
        report_and_stop();
    end
endmodule : tb_hcc_host_if
`default_nettype wire
